// ### core/cts_core.sv
// current transformer supervision: pick-up, timer, events, record log
// assumes currents in hundredths of nominal from same-clock logic
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "cts_params.svh"
module cts_core #(
    parameter int MS_CYC = `CTS_MS_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        block_i,
    input  wire logic [15:0] ph1_i,
    input  wire logic [15:0] ph2_i,
    input  wire logic [15:0] ph3_i,
    input  wire logic [15:0] res_calc_i,
    input  wire logic [15:0] residual_current_i,
    input  wire logic [15:0] seq_pos_i,
    input  wire logic [15:0] seq_neg_i,
    input  wire logic [15:0] sum_diff_i,
    input  wire logic [15:0] sum_ang_i,
    input  wire logic [2:0]  group_i,
    output logic             start_o,
    output logic             blocked_o,
    output logic             alarm_activation_o,
    output logic             evt_alarm_on_o,
    output logic             evt_alarm_off_o,
    output logic             evt_block_on_o,
    output logic             evt_block_off_o,
    output logic      [31:0] evt_time_o
);
    // ------------------------------------------------------------
    // settings
    // ------------------------------------------------------------
    logic [3:0]  ctrl_r, lsel_r;         // event and residual select, record read index
    logic [15:0] hi_r, lo_r;             // high and low phase limits
    logic [15:0] unb_r, seq_r;           // min/max and i2/i1 ratios, 0.01 %
    logic [15:0] pickup_threshold_r;     // residual difference limit
    logic [15:0] definite_time_delay_r;  // delay in 5 ms steps
    logic        clr;                    // counter clear pulse
    // write side of the register port
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_r                <= `CTS_R_CTRL;
            hi_r                  <= `CTS_R_HIGH;
            lo_r                  <= `CTS_R_LOW;
            unb_r                 <= `CTS_R_UNB;
            seq_r                 <= `CTS_R_SEQ;
            pickup_threshold_r    <= `CTS_R_SUMD;
            definite_time_delay_r <= `CTS_R_DELAY;
            lsel_r                <= 4'h0;
        end
        else if (wr_i)
        begin
            case (addr_i)
                `CTS_A_CTRL:  ctrl_r <= {1'b0, wdata_i[2:0]};
                `CTS_A_HIGH:  hi_r <= wdata_i[15:0];
                `CTS_A_LOW:   lo_r <= wdata_i[15:0];
                `CTS_A_UNB:   unb_r <= wdata_i[15:0];
                `CTS_A_SEQ:   seq_r <= wdata_i[15:0];                    // [R19]
                `CTS_A_SUMD:  pickup_threshold_r <= wdata_i[15:0];
                `CTS_A_DELAY: definite_time_delay_r <= wdata_i[15:0];   // [R20]
                `CTS_A_LSEL:  lsel_r <= wdata_i[3:0];
                default:      lsel_r <= lsel_r;
            endcase
        end
    end
    assign clr = wr_i && (addr_i == `CTS_A_CTRL) && wdata_i[`CTS_B_CLR];
    // ------------------------------------------------------------
    // time base and blocking synchroniser
    // ------------------------------------------------------------
    logic [31:0] ms_r, div_r;            // millisecond time stamp, clock divider
    logic [2:0]  stp_r;                  // milliseconds within a cycle
    logic        tick, blk_smp_r;        // program cycle start, blocking as sampled
    logic [1:0]  bsy_r;                  // blocking synchroniser
    // millisecond counter and 5 ms program cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_r <= 32'h0;
            ms_r  <= 32'h0;
            stp_r <= 3'h0;
        end
        else if (div_r == 32'(MS_CYC - 1))
        begin
            div_r <= 32'h0;
            ms_r  <= ms_r + 32'h1;
            stp_r <= (stp_r == 3'(`CTS_STEP_MS - 1)) ? 3'h0 : stp_r + 3'h1;
        end
        else
            div_r <= div_r + 32'h1;
    end
    assign tick = (div_r == 32'(MS_CYC - 1)) && (stp_r == 3'(`CTS_STEP_MS - 1));
    // two flops, then sampled once per program cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bsy_r     <= 2'h0;
            blk_smp_r <= 1'b0;
        end
        else
        begin
            bsy_r <= {bsy_r[0], block_i};
            if (tick)
                blk_smp_r <= bsy_r[1];  // [R1]
        end
    end
    // ------------------------------------------------------------
    // pick-up conditions
    // ------------------------------------------------------------
    cts_pkg::cts_state_t st_r;           // supervision state
    logic        act;                    // condition already picked up
    logic [31:0] hi_e, lo_e, sd_e;       // limits with reset ratio
    logic [15:0] mx, mn;                 // phase max and min
    logic        hi_any, lo_all, unb, sq, res_ok, pick;
    logic [4:0]  fcode;                  // fault status code
    assign act  = (st_r == cts_pkg::CTS_START) || (st_r == cts_pkg::CTS_ALARM);
    // relaxed limits once picked up, so a marginal value does not chatter
    assign hi_e = act ? (32'(hi_r) * `CTS_HYS_UP) : (32'(hi_r) * `CTS_PCT);   // [R18]
    assign lo_e = act ? (32'(lo_r) * `CTS_HYS_DN) : (32'(lo_r) * `CTS_PCT);   // [R18]
    assign sd_e = act ? (32'(pickup_threshold_r) * `CTS_HYS_DN)
                      : (32'(pickup_threshold_r) * `CTS_PCT);
    // phase extremes
    always_comb
    begin
        mx = (ph1_i > ph2_i) ? ph1_i : ph2_i;
        mx = (ph3_i > mx) ? ph3_i : mx;
        mn = (ph1_i < ph2_i) ? ph1_i : ph2_i;
        mn = (ph3_i < mn) ? ph3_i : mn;
    end
    assign hi_any = 32'(mx) * `CTS_PCT > hi_e;                               // [R8]
    assign lo_all = 32'(mx) * `CTS_PCT < lo_e;                               // [R9]
    assign unb    = 32'(mn) * `CTS_FULL <= 32'(unb_r) * 32'(mx);
    assign sq     = 32'(seq_neg_i) * `CTS_FULL > 32'(seq_r) * 32'(seq_pos_i); // [R19]
    // summed phases checked against measured residual when selected
    assign res_ok = !ctrl_r[`CTS_B_RES]
                    || (32'(sum_diff_i) * `CTS_PCT >= sd_e);                 // [R10] [R11]
    assign pick   = !hi_any && !lo_all && unb && sq && res_ok;
    assign fcode  = {!res_ok, !sq, !unb, lo_all, hi_any};
    // ------------------------------------------------------------
    // supervision state and definite time
    // ------------------------------------------------------------
    logic [15:0] cnt_r, cnt_nxt;         // elapsed steps
    cts_pkg::cts_state_t st_nxt;         // next supervision state
    // only a fixed step count, no curve characteristic
    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        if (tick)
        begin
            if (!pick)
            begin
                st_nxt  = cts_pkg::CTS_IDLE;   // [R21]
                cnt_nxt = 16'h0;               // [R22]
            end
            else if (bsy_r[1])
            begin
                st_nxt  = cts_pkg::CTS_BLKD;   // [R3] [R4]
                cnt_nxt = 16'h0;
            end
            else
            begin
                case (st_r)
                    cts_pkg::CTS_START:
                    begin
                        cnt_nxt = cnt_r + 16'h1;              // [R6] [R7]
                        if (cnt_nxt >= definite_time_delay_r)
                            st_nxt = cts_pkg::CTS_ALARM;
                    end
                    cts_pkg::CTS_ALARM: st_nxt = cts_pkg::CTS_ALARM;
                    default:
                    begin
                        st_nxt  = cts_pkg::CTS_START;         // [R2]
                        cnt_nxt = 16'h0;
                    end
                endcase
            end
        end
    end
    // state update
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r  <= cts_pkg::CTS_IDLE;
            cnt_r <= 16'h0;
        end
        else
        begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    assign start_o            = (st_r == cts_pkg::CTS_START);
    assign alarm_activation_o = (st_r == cts_pkg::CTS_ALARM);
    assign blocked_o          = (st_r == cts_pkg::CTS_BLKD);
    // ------------------------------------------------------------
    // events, counter, record log
    // ------------------------------------------------------------
    logic a_on, a_off, b_on, b_off;      // raw status changes
    logic [15:0] acnt_r, bcnt_r;         // cumulative counters
    logic [3:0]  wp_r;                   // next record slot
    logic [31:0] lt_m [`CTS_LOG_N], li_m [`CTS_LOG_N]; // time stamp; event, status, remaining
    logic [127:0] lc_m [`CTS_LOG_N];     // trigger currents, four words
    assign a_on  = (st_nxt == cts_pkg::CTS_ALARM) && (st_r != cts_pkg::CTS_ALARM);
    assign a_off = (st_r == cts_pkg::CTS_ALARM) && (st_nxt != cts_pkg::CTS_ALARM);
    assign b_on  = (st_nxt == cts_pkg::CTS_BLKD) && (st_r != cts_pkg::CTS_BLKD);
    assign b_off = (st_r == cts_pkg::CTS_BLKD) && (st_nxt != cts_pkg::CTS_BLKD);
    // filtered event strobes with time stamp of the change
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            evt_alarm_on_o  <= 1'b0;
            evt_alarm_off_o <= 1'b0;
            evt_block_on_o  <= 1'b0;
            evt_block_off_o <= 1'b0;
            evt_time_o      <= 32'h0;
        end
        else
        begin
            evt_alarm_on_o  <= a_on && ctrl_r[`CTS_B_ON];     // [R12]
            evt_alarm_off_o <= a_off && ctrl_r[`CTS_B_OFF];   // [R12] [R21]
            evt_block_on_o  <= b_on && ctrl_r[`CTS_B_ON];
            evt_block_off_o <= b_off && ctrl_r[`CTS_B_OFF];
            if (a_on || a_off || b_on || b_off)
                evt_time_o <= ms_r;                           // [R13]
        end
    end
    // counters: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acnt_r <= 16'h0;
            bcnt_r <= 16'h0;
        end
        else
        begin
            acnt_r <= (clr ? 16'h0 : acnt_r) + {15'h0, a_on};  // [R14]
            bcnt_r <= (clr ? 16'h0 : bcnt_r) + {15'h0, b_on};  // [R14]
        end
    end
    // ring of records written on every on event
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wp_r <= 4'h0;
        else if (a_on || b_on)
        begin
            wp_r <= (wp_r == 4'(`CTS_LOG_N - 1)) ? 4'h0 : wp_r + 4'h1;  // [R15]
            lt_m[wp_r]    <= ms_r;                                       // [R16]
            li_m[wp_r]    <= {b_on, 1'b0, fcode, group_i, 6'h0,
                              definite_time_delay_r - cnt_r};
            lc_m[wp_r]    <= {16'h0, res_calc_i, seq_neg_i, seq_pos_i,
                              residual_current_i, ph3_i, ph2_i, ph1_i};
        end
    end
    // ------------------------------------------------------------
    // read side, data valid the cycle after the strobe
    // ------------------------------------------------------------
    logic [3:0] ls;                      // record index, slot 0 when out of range
    assign ls = (lsel_r < 4'(`CTS_LOG_N)) ? lsel_r : 4'h0;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_o <= 32'h0;
        else if (rd_i)
        begin
            case (addr_i)
                `CTS_A_CTRL:  rdata_o <= {28'h0, ctrl_r};
                `CTS_A_HIGH:  rdata_o <= {16'h0, hi_r};
                `CTS_A_LOW:   rdata_o <= {16'h0, lo_r};
                `CTS_A_UNB:   rdata_o <= {16'h0, unb_r};
                `CTS_A_SEQ:   rdata_o <= {16'h0, seq_r};
                `CTS_A_SUMD:  rdata_o <= {16'h0, pickup_threshold_r};
                `CTS_A_DELAY: rdata_o <= {16'h0, definite_time_delay_r};
                `CTS_A_STAT:  rdata_o <= {wp_r, 4'h0, fcode, blk_smp_r, cnt_r, st_r};
                `CTS_A_CNT:   rdata_o <= {bcnt_r, acnt_r};
                `CTS_A_DIFF:  rdata_o <= {sum_ang_i, sum_diff_i};   // [R17]
                `CTS_A_LSEL:  rdata_o <= {28'h0, lsel_r};
                8'h40:        rdata_o <= lt_m[ls];
                8'h44:        rdata_o <= li_m[ls];
                8'h48:        rdata_o <= lc_m[ls][31:0];
                8'h4C:        rdata_o <= lc_m[ls][63:32];
                8'h50:        rdata_o <= lc_m[ls][95:64];
                8'h54:        rdata_o <= lc_m[ls][127:96];
                default:      rdata_o <= 32'h0;
            endcase
        end
        else
            rdata_o <= 32'h0;
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_pick_free; tick && pick && !bsy_r[1]; endsequence
    sequence s_pick_blk; tick && pick && bsy_r[1]; endsequence
    AST_BLK_SAMPLE: assert property (!tick |=> $stable(blk_smp_r)) // [R1]
        else $error("blocking sample moved outside program cycle");
    AST_START: assert property (s_pick_free and !act |=> start_o) // [R2]
        else $error("start missing after free pick-up");
    AST_BLOCKED: assert property (s_pick_blk |=> blocked_o && !start_o) // [R3]
        else $error("blocked missing after blocked pick-up");
    AST_DROP: assert property (start_o ##0 s_pick_blk |=> !start_o && cnt_r == 16'h0) // [R4]
        else $error("start not dropped by blocking");
    AST_DT: assert property ($rose(alarm_activation_o) |-> cnt_r >= definite_time_delay_r) // [R6] [R7]
        else $error("alarm before delay elapsed");
    AST_HIGH: assert property (tick && !act && hi_any |=> !start_o && !alarm_activation_o) // [R8]
        else $error("activation above high limit");
    AST_LOW: assert property (tick && !act && lo_all |=> !start_o) // [R9]
        else $error("activation below low limit");
    AST_RES: assert property (tick && !act && ctrl_r[2] && sum_diff_i < pickup_threshold_r
                              |=> !start_o) // [R11]
        else $error("activation below residual difference");
    AST_STAMP: assert property ((a_on || b_on) |=> evt_time_o == $past(ms_r)) // [R13]
        else $error("event time stamp wrong");
    AST_CLR: assert property (clr && !a_on |=> acnt_r == 16'h0) // [R14]
        else $error("counter not cleared");
    AST_RING: assert property ((a_on || b_on) && wp_r == 4'hB |=> wp_r == 4'h0) // [R15]
        else $error("record ring did not wrap");
    AST_OFF: assert property (alarm_activation_o && tick && !pick
                              |=> !alarm_activation_o ##0 $past(a_off)) // [R21]
        else $error("alarm not released");
    AST_EARLY: assert property (start_o && tick && !pick |=> !start_o && cnt_r == 16'h0
                                ##1 !alarm_activation_o) // [R22]
        else $error("timer not cleared on early release");
endmodule

// ### core/cts_params.svh
// constants of the current transformer supervision block
// assumes a 25 MHz clock and a plain single-cycle register port
// Operation
// [R1] sample blocking input at each program cycle
// [R2] pick-up without blocking asserts start, runs timer
// [R3] pick-up with blocking asserts blocked, nothing more
// [R4] blocking drops start like a pick-up release
// [R5] blocker asserts 5 ms before delay ends; the bench raises it one clock after start is seen
// [R6] only definite fixed time delay exists
// [R7] alarm only when fault persists full delay
// [R8] any phase above high limit suppresses
// [R9] all phases below low limit suppresses
// [R10] residual selected compares summed against measured
// [R11] residual difference below threshold suppresses activation
// [R12] on/off events stored per user selection
// [R13] every event carries change time stamp
// [R14] clearable count of alarm and blocked events
// [R15] last twelve records kept, oldest overwritten
// [R16] record holds time, event, currents, remaining, status
// [R17] expose sum/residual magnitude and angle difference
// [R18] reset ratios 97 and 103 percent
// [R19] negative/positive ratio above threshold, default 49%
// [R20] delay in 5 ms steps, default 0.5 s
// [R21] alarm drops with off event when fault clears
// [R22] timer cleared when fault vanishes early
`ifndef CTS_PARAMS_SVH
`define CTS_PARAMS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CTS_A_CTRL    8'h00
`define CTS_A_HIGH    8'h04
`define CTS_A_LOW     8'h08
`define CTS_A_UNB     8'h0C
`define CTS_A_SEQ     8'h10
`define CTS_A_SUMD    8'h14
`define CTS_A_DELAY   8'h18
`define CTS_A_STAT    8'h1C
`define CTS_A_CNT     8'h20
`define CTS_A_DIFF    8'h24
`define CTS_A_LSEL    8'h28
`define CTS_A_LOG     8'h40
// ------------------------------------------------------------
// control fields and reset values
// ------------------------------------------------------------
`define CTS_B_ON      0
`define CTS_B_OFF     1
`define CTS_B_RES     2
`define CTS_B_CLR     3
`define CTS_R_CTRL    4'h3
`define CTS_R_HIGH    16'h0078
`define CTS_R_LOW     16'h000A
`define CTS_R_UNB     16'h03E8
`define CTS_R_SEQ     16'h1324
`define CTS_R_SUMD    16'h000A
`define CTS_R_DELAY   16'h0064
// ------------------------------------------------------------
// timing and sizes
// ------------------------------------------------------------
`define CTS_CLK_NS    40
`define CTS_MS_NS     1000000
`define CTS_MS_CYC    (`CTS_MS_NS / `CTS_CLK_NS)
`define CTS_STEP_MS   5
`define CTS_BLK_LEAD_MS 5
`define CTS_LOG_N     12
`define CTS_PCT       100
`define CTS_HYS_UP    103
`define CTS_HYS_DN    97
`define CTS_FULL      10000
`endif

// ### core/cts_pkg.sv
// types of the current transformer supervision block
// assumes cts_params.svh supplies the numeric constants
package cts_pkg;
    // supervision state
    typedef enum logic [1:0] {
        CTS_IDLE  = 2'b00,
        CTS_START = 2'b01,
        CTS_ALARM = 2'b10,
        CTS_BLKD  = 2'b11
    } cts_state_t;
endpackage

// ### tb/cts_block_matrix.sv
// partner model: blocking matrix feeding block_i and event logger counting pulses
// assumes the bench requests blocking by level on the same clock as the block
`timescale 1ns/1ps
module cts_block_matrix (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic        aon_i,
    input  wire logic        aoff_i,
    input  wire logic        bon_i,
    input  wire logic        boff_i,
    output logic             block_o,
    output logic      [31:0] cnt_o
);
    // ------------------------------------------------------------
    // blocking source
    // ------------------------------------------------------------
    // level copied from the request; the bench raises it ticks before the delay ends
    always_ff @(posedge clk_i)
    begin
        block_o <= rst_i ? 1'b0 : req_i;
    end
    // ------------------------------------------------------------
    // event logger
    // ------------------------------------------------------------
    // one byte a pulse kind: alarm on, alarm off, block on, block off
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_o <= 32'h0;
        else
            cnt_o <= cnt_o + {7'h0, boff_i, 7'h0, bon_i, 7'h0, aoff_i, 7'h0, aon_i};
    end
endmodule

// ### tb/test_current_transformer_supervision.sv
// testbench of the supervision block: register port tasks and scenario sequence
// assumes the design and the partner model share one 25 MHz clock
`timescale 1ns/1ps
`include "cts_params.svh"
module test_current_transformer_supervision;
    localparam int MS  = 4;            // shortened millisecond
    localparam int TK  = 5 * MS;       // cycles of one program cycle
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr_i = 8'h0;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [15:0] ph1 = 16'h64, ph2 = 16'h64, ph3 = 16'h64, rc = 16'h0, rm = 16'h0;
    logic [15:0] sd = 16'h1234;        // summed minus measured residual magnitude
    logic        req = 1'b0;
    logic [31:0] rdata_o, evt_time_o, ec;
    logic        start_o, blocked_o, alarm_o, aon, aoff, bon, boff, block_i;
    int          error_cnt = 0, checks = 0, cyc = 0, n;
    // clock source
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    cts_core #(.MS_CYC(MS)) u_cts_core (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .block_i(block_i),
        .ph1_i(ph1), .ph2_i(ph2), .ph3_i(ph3), .res_calc_i(rc), .residual_current_i(rm),
        .seq_pos_i(16'h0043), .seq_neg_i(16'h0021), .sum_diff_i(sd),
        .sum_ang_i(16'hFF9C), .group_i(3'h5), .start_o(start_o), .blocked_o(blocked_o),
        .alarm_activation_o(alarm_o), .evt_alarm_on_o(aon), .evt_alarm_off_o(aoff),
        .evt_block_on_o(bon), .evt_block_off_o(boff), .evt_time_o(evt_time_o));
    cts_block_matrix u_cts_block_matrix (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .aon_i(aon), .aoff_i(aoff), .bon_i(bon), .boff_i(boff), .block_o(block_i),
        .cnt_o(ec));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // value compare, reports and counts
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // single-cycle register write
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // read, data taken in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask
    // phase magnitudes, changed on the clock
    task set_ph(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge clk_i);
        ph1 <= a;
        ph2 <= b;
        ph3 <= c;
    endtask
    // wait for a state output, s: 0 start 1 alarm 2 blocked 3 alarm low
    task wt(input int s, input int lim);
        n = 0;
        while (n < lim && ({~alarm_o, blocked_o, alarm_o, start_o} >> s) % 2 !== 1)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(n < lim, 1'b1);
    endtask
    // verdict, single exit of the run
    task final_report;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            final_report;
        end
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`CTS_A_CTRL, 32'h3);
        rd(`CTS_A_HIGH, 32'h78);
        rd(`CTS_A_DELAY, 32'h64);
        rd(8'h3C, 32'h0);
        rd(`CTS_A_DIFF, 32'hFF9C1234);
        wr(`CTS_A_DELAY, 32'h3);
        $display("test regs done");
        // lost phase: start, then alarm after exactly three program cycles
        set_ph(16'h0, 16'h64, 16'h64);
        wt(0, 3 * TK);
        wt(1, 5 * TK);
        chk(n, 3 * TK);
        @(posedge clk_i);
        #1;
        chk(ec[7:0], 8'h1);
        chk(evt_time_o <= cyc / MS + 1 && evt_time_o + 6 >= cyc / MS, 1'b1);
        rd(`CTS_A_CNT, 32'h1);
        wr(`CTS_A_LSEL, 32'h0);
        rd(8'h48, 32'h00640000);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= 8'h44;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk({rdata_o[31], rdata_o[24:22]}, 4'h5);
        set_ph(16'h64, 16'h64, 16'h64);
        wt(3, 2 * TK);
        repeat (3) @(posedge clk_i);
        chk(ec[15:8], 8'h1);
        $display("test alarm done");
        // fault too short: timer cleared, no alarm
        set_ph(16'h0, 16'h64, 16'h64);
        wt(0, 3 * TK);
        set_ph(16'h64, 16'h64, 16'h64);
        repeat (6 * TK) @(posedge clk_i);
        chk(ec[7:0], 8'h1);
        // high phase, then all phases low: never starts
        set_ph(16'h0, 16'h82, 16'h64);
        repeat (3 * TK) @(posedge clk_i);
        chk(start_o, 1'b0);
        set_ph(16'h0, 16'h5, 16'h5);
        repeat (3 * TK) @(posedge clk_i);
        chk(start_o, 1'b0);
        $display("test limits done");
        // blocking arrives while started
        set_ph(16'h0, 16'h64, 16'h64);
        wt(0, 3 * TK);
        @(posedge clk_i);
        req <= 1'b1;
        wt(2, 2 * TK);
        chk(start_o, 1'b0);
        repeat (3) @(posedge clk_i);
        chk(ec[23:16], 8'h1);
        rd(`CTS_A_CNT, 32'h00010001);
        rd(`CTS_A_STAT, 32'h20040003);
        repeat (4 * TK) @(posedge clk_i);
        chk({start_o, alarm_o, blocked_o}, 3'h1);
        set_ph(16'h64, 16'h64, 16'h64);
        @(posedge clk_i);
        req <= 1'b0;
        repeat (3 * TK) @(posedge clk_i);
        chk(ec[31:24], 8'h1);
        $display("test block done");
        // residual selected: equal sums suppress, a difference lets it start
        wr(`CTS_A_CTRL, 32'h7);
        rc <= 16'h32;
        rm <= 16'h32;
        sd <= 16'h0;
        set_ph(16'h0, 16'h64, 16'h64);
        repeat (3 * TK) @(posedge clk_i);
        chk(start_o, 1'b0);
        rm <= 16'h0;
        sd <= 16'h32;
        wt(0, 3 * TK);
        set_ph(16'h64, 16'h64, 16'h64);
        wr(`CTS_A_CTRL, 32'hB);
        rd(`CTS_A_CNT, 32'h0);
        $display("test residual done");
        final_report;
    end
endmodule
